// ### bench/pif_flags_one_checker.sv
// assertions on the flag register ports
`timescale 1ns/1ps
`default_nettype none
module pif_flags_checker (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// events, state and interrupt
	input wire logic       osc_fail_event,
	input wire logic       cmp_two_event,
	input wire logic       cmp_one_event,
	input wire logic       nvm_write_done_event,
	input wire logic       serial_bus_collision_event,
	input wire logic       cmp_four_event,
	input wire logic       cmp_three_event,
	input wire logic       capcmp_two_event,
	input wire logic [7:0] peripheral_event_flags_one,
	input wire logic       irq,
	// bus select, the only way besides reset a flag may drop
	input wire logic       psel
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	osc_sets_a: assert property (osc_fail_event |-> ##2 peripheral_event_flags_one[7])
		else $error("osc flag missed");
	cmp_two_a: assert property (cmp_two_event |=> ##1 peripheral_event_flags_one[6])
		else $error("cmp two flag missed");
	nvm_done_a: assert property (nvm_write_done_event |-> ##2 peripheral_event_flags_one[4])
		else $error("nvm flag missed");
	bus_coll_a: assert property (serial_bus_collision_event |-> ##2 peripheral_event_flags_one[3])
		else $error("collision flag missed");
	cmp_one_a: assert property (cmp_one_event |-> ##2 peripheral_event_flags_one[5])
		else $error("cmp one flag missed");
	cmp_four_a: assert property (cmp_four_event |-> ##2 peripheral_event_flags_one[2])
		else $error("cmp four flag missed");
	cmp_three_a: assert property (cmp_three_event |-> ##2 peripheral_event_flags_one[1])
		else $error("cmp three flag missed");
	capcmp_two_a: assert property (capcmp_two_event |-> ##2 peripheral_event_flags_one[0])
		else $error("capcmp two flag missed");
	irq_cause_a: assert property (irq |-> peripheral_event_flags_one != 8'h00)
		else $error("irq with no flag");
	flags_sticky_a: assert property (!$past(psel) && !psel |=>
		(peripheral_event_flags_one & $past(peripheral_event_flags_one)) == $past(peripheral_event_flags_one))
		else $error("flag dropped with no bus access");
endmodule
bind pif_flags_one pif_flags_checker u_chk (
	.clk                        (clk),
	.rst_n                      (rst_n),
	.osc_fail_event             (osc_fail_event),
	.cmp_two_event              (cmp_two_event),
	.cmp_one_event              (cmp_one_event),
	.nvm_write_done_event       (nvm_write_done_event),
	.serial_bus_collision_event (serial_bus_collision_event),
	.cmp_four_event             (cmp_four_event),
	.cmp_three_event            (cmp_three_event),
	.capcmp_two_event           (capcmp_two_event),
	.peripheral_event_flags_one (peripheral_event_flags_one),
	.irq                        (irq),
	.psel                       (psel)
);
`default_nettype wire

// ### bench/pif_src_model.sv
// peripheral sources raising event requests one cycle after the bench fires them
`timescale 1ns/1ps
`default_nettype none
module pif_src_model (
	// clock
	input wire logic       clk,
	// requests from the bench, events to the block
	input wire logic [7:0] fire,
	output var logic [7:0] ev = 8'h00
);
	always @(posedge clk) ev <= fire;
endmodule
`default_nettype wire

// ### bench/test_pif_flags_one.sv
// random and corner tests of the peripheral event flag register
`timescale 1ns/1ps
`default_nettype none
module test_pif_flags_one;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, s = 42;
	logic [7:0]  fire = 0, ev, flags, m, r, w;
	int          err_total = 0, n_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	pif_src_model u_src (.clk(clk), .fire(fire), .ev(ev));
	pif_flags_one u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.osc_fail_event(ev[7]), .cmp_two_event(ev[6]), .cmp_one_event(ev[5]), .nvm_write_done_event(ev[4]),
		.serial_bus_collision_event(ev[3]), .cmp_four_event(ev[2]), .cmp_three_event(ev[1]),
		.capcmp_two_event(ev[0]), .peripheral_event_flags_one(flags), .irq(irq));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request until pready is seen high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// an event landing on the same edge as a software write or clear must win
	task automatic race(input logic [7:0] p, input logic [11:0] a, input logic [31:0] d);
		fire <= p;
		fork
			@(posedge clk) fire <= 8'h00;
			bus(1'b1, a, d);
		join
		bus(1'b0, 12'h000, 32'h0);
		chk(rd, 32'(p));
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) if (++cyc > 4000) begin
		err_total++;
		conclude;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		// mask stays zero, so every flag below sets with its interrupt off
		for (int k = 0; k < 8; k++) begin
			fire <= 8'h01 << k;
			@(posedge clk) fire <= 8'h00;
			// the model adds a cycle and the flag lands one later
			repeat (2) @(posedge clk);
			bus(1'b0, 12'h000, 32'h0);
			chk(rd, 32'h1 << k);
			chk(32'(flags), 32'h1 << k);
			chk(32'(irq), 32'h0);
			chk(32'(e), 32'h0);
			bus(1'b1, 12'h000, 32'h0);
		end
		s = xs(s);
		fire <= s[7:0];
		@(posedge clk);
		bus(1'b0, 12'h00c, 32'h0);
		fire <= 8'h00;
		chk(rd, 32'(s[7:0]));
		$display("sources done");
		for (int i = 0; i < 20; i++) begin
			s = xs(s);
			m = s[7:0];
			r = s[15:8];
			w = s[23:16];
			bus(1'b1, 12'h004, 32'(m));
			bus(1'b1, 12'h000, 32'(r));
			bus(1'b0, 12'h008, 32'h0);
			chk(rd, 32'(m & r));
			chk(32'(irq), 32'(|(m & r)));
			bus(1'b1, 12'h008, 32'(w));
			bus(1'b0, 12'h000, 32'h0);
			chk(rd, 32'(r & ~w));
			chk(32'(irq), 32'(|(m & r & ~w)));
		end
		bus(1'b0, 12'h010, 32'h0);
		chk(32'(e), 32'h1);
		chk(rd, 32'h0);
		$display("masks done");
		race(8'h08, 12'h008, 32'h000000ff);
		race(8'h80, 12'h000, 32'h0);
		$display("races done");
		// load flags and mask, then a reset in mid-run must clear both
		bus(1'b1, 12'h004, 32'h000000ff);
		bus(1'b1, 12'h000, 32'h000000a5);
		@(posedge clk);
		chk(32'(irq), 32'h1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'(irq), 32'h0);
		chk(32'(flags), 32'h0);
		bus(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		$display("reset done");
		conclude;
	end
endmodule
`default_nettype wire

// ### src/pif_consts.svh
// offsets, field positions and reset values for the peripheral event flag block
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH

`define PIF_OFF_FLAGS      12'h000
`define PIF_OFF_MASK       12'h004
`define PIF_OFF_IRQ_STATUS 12'h008
`define PIF_OFF_SOURCES    12'h00c

`define PIF_BIT_CAPCMP_TWO  0
`define PIF_BIT_CMP_THREE   1
`define PIF_BIT_CMP_FOUR    2
`define PIF_BIT_SERIAL_BCOL 3
`define PIF_BIT_NVM_DONE    4
`define PIF_BIT_CMP_ONE     5
`define PIF_BIT_CMP_TWO     6
`define PIF_BIT_OSC_FAIL    7

`define PIF_FLAGS_RESET 8'h00
`define PIF_MASK_RESET  8'h00

`endif

// ### src/pif_flag_bit.sv
// one sticky event flag: hardware set beats software clear
`timescale 1ns/1ps
`default_nettype none
module pif_flag_bit (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// event and software access
	input  wire logic set_event,
	input  wire logic sw_write,
	input  wire logic sw_value,
	input  wire logic w1c_clear,
	// state
	output logic      flag
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (set_event) begin
			flag <= 1'b1;
		end else if (w1c_clear) begin
			flag <= 1'b0;
		end else if (sw_write) begin
			flag <= sw_value;
		end
	end
endmodule
`default_nettype wire

// ### src/pif_flags_one.sv
// peripheral event flag register one with apb access and a masked interrupt
//
// Overview of operation
// - each flag reads 1 from its source event or a software write of 1 until software clears it, else 0
// - bit 6 sets on a second comparator event
// - bit 4 sets when a data nvm write completes
// - bit 3 sets on a serial port bus collision
// - bit 7 osc fail, 5 cmp one, 2 cmp four, 1 cmp three, 0 capcmp two
`timescale 1ns/1ps
`default_nettype none
`include "pif_consts.svh"
module pif_flags_one
	import pif_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// event pulses from the peripherals
	input  wire logic        osc_fail_event,
	input  wire logic        cmp_two_event,
	input  wire logic        cmp_one_event,
	input  wire logic        nvm_write_done_event,
	input  wire logic        serial_bus_collision_event,
	input  wire logic        cmp_four_event,
	input  wire logic        cmp_three_event,
	input  wire logic        capcmp_two_event,
	// flag state and interrupt
	output logic [7:0]       peripheral_event_flags_one,
	output logic             irq
);
	pif_flags_t     flags;
	pif_flags_t     events;
	pif_flags_t     mask;
	pif_flags_t     next_flags_wr;
	pif_flags_t     clear_bits;
	logic           sel_flags;
	logic           sel_mask;
	logic           sel_status;
	logic           sel_sources;
	logic           mapped;
	logic           setup_seen;
	logic           acc;
	logic           wr_flags;
	logic           wr_mask;
	logic           wr_status;
	logic           next_irq;
	logic [31:0]    next_prdata;
	pif_apb_phase_t phase;
	pif_apb_phase_t next_phase;

	assign events[`PIF_BIT_CMP_TWO] = cmp_two_event;
	assign events[`PIF_BIT_NVM_DONE] = nvm_write_done_event;
	assign events[`PIF_BIT_SERIAL_BCOL] = serial_bus_collision_event;
	assign events[`PIF_BIT_OSC_FAIL] = osc_fail_event;
	assign events[`PIF_BIT_CMP_ONE] = cmp_one_event;
	assign events[`PIF_BIT_CMP_FOUR] = cmp_four_event;
	assign events[`PIF_BIT_CMP_THREE] = cmp_three_event;
	assign events[`PIF_BIT_CAPCMP_TWO] = capcmp_two_event;

	// address decode, shared by the write strobes and the error response
	assign sel_flags   = (paddr == `PIF_OFF_FLAGS);
	assign sel_mask    = (paddr == `PIF_OFF_MASK);
	assign sel_status  = (paddr == `PIF_OFF_IRQ_STATUS);
	assign sel_sources = (paddr == `PIF_OFF_SOURCES);
	assign mapped      = sel_flags || sel_mask || sel_status || sel_sources;

	// phase is SETUP only in the first access cycle, the one that answers
	assign setup_seen = (phase == PIF_APB_SETUP);
	// a write lands only at the edge where the master sees pready, so a held access writes once
	assign acc       = psel && penable && pready && setup_seen;
	assign wr_flags  = acc && pwrite && sel_flags;
	assign wr_mask   = acc && pwrite && sel_mask;
	assign wr_status = acc && pwrite && sel_status;
	// only the low byte has storage; the upper write bits are dropped on purpose
	assign next_flags_wr = pwdata[7:0];
	assign clear_bits    = wr_status ? next_flags_wr : 8'h00;

	// set path ignores mask and enables
	for (genvar i = 0; i < 8; i++) begin : g_flag
		pif_flag_bit u_bit (
			.clk       (clk),
			.rst_n     (rst_n),
			.set_event (events[i]),
			.sw_write  (wr_flags),
			.sw_value  (next_flags_wr[i]),
			.w1c_clear (clear_bits[i]),
			.flag      (flags[i])
		);
	end

	// mask gates the interrupt and the irq status read, never the flags themselves
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= `PIF_MASK_RESET;
		end else if (wr_mask) begin
			mask <= pwdata[7:0];
		end
	end

	// phase of the bus as seen at the last edge; an illegal order falls back to idle
	always_comb begin
		next_phase = PIF_APB_IDLE;
		case (phase)
			PIF_APB_IDLE: begin
				if (psel && !penable) begin
					next_phase = PIF_APB_SETUP;
				end
			end
			PIF_APB_SETUP: begin
				if (psel && penable) begin
					next_phase = PIF_APB_ACCESS;
				end else if (psel) begin
					next_phase = PIF_APB_SETUP;
				end
			end
			PIF_APB_ACCESS: begin
				if (psel && !penable) begin
					next_phase = PIF_APB_SETUP;
				end else if (psel && penable) begin
					next_phase = PIF_APB_ACCESS;
				end
			end
			default: begin
				next_phase = PIF_APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= PIF_APB_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	// read data is picked at the setup edge, so a flag set in that cycle shows on the next read
	always_comb begin
		next_prdata = 32'h00000000;
		case (paddr)
			`PIF_OFF_FLAGS: begin
				next_prdata = {24'h000000, flags};
			end
			`PIF_OFF_MASK: begin
				next_prdata = {24'h000000, mask};
			end
			`PIF_OFF_IRQ_STATUS: begin
				next_prdata = {24'h000000, flags & mask};
			end
			`PIF_OFF_SOURCES: begin
				next_prdata = {24'h000000, events};
			end
			default: begin
				next_prdata = 32'h00000000;
			end
		endcase
	end

	// answer is registered: pready stands for exactly the first access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// unmapped offsets answer with an error, zero data and no write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= next_prdata;
		end
	end

	// flag state visible to the core
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_event_flags_one <= `PIF_FLAGS_RESET;
		end else begin
			peripheral_event_flags_one <= flags;
		end
	end

	// level interrupt: any pending flag whose mask bit is set
	assign next_irq = |(flags & mask);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end
endmodule
`default_nettype wire

// ### src/pif_pkg.sv
// types shared by the peripheral event flag block
`default_nettype none
package pif_pkg;
	typedef logic [7:0] pif_flags_t;
	typedef enum logic [1:0] {
		PIF_APB_IDLE,
		PIF_APB_SETUP,
		PIF_APB_ACCESS
	} pif_apb_phase_t;
endpackage
`default_nettype wire
